/* File: pwmsc_pkg.sv */
// constants for the single-channel buffered pwm generator
package pwmsc_pkg;
  // register byte offsets
  localparam logic [7:0] PWMSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PWMSC_OFS_OUTC = 8'h04;
  localparam logic [7:0] PWMSC_OFS_COUNT = 8'h08;
  localparam logic [7:0] PWMSC_OFS_DUTY = 8'h0C;
  localparam logic [7:0] PWMSC_OFS_PERIOD = 8'h10;
  localparam logic [7:0] PWMSC_OFS_BUFFER = 8'h14;
  localparam logic [7:0] PWMSC_OFS_STATUS = 8'h18;
  // control register fields
  localparam int PWMSC_CTRL_RUN = 0;
  localparam int PWMSC_CTRL_CLR = 1;
  localparam int PWMSC_CTRL_BUF = 2;
  localparam int PWMSC_CTRL_XCLR = 3;
  localparam int PWMSC_CTRL_PS_LO = 4;
  localparam int PWMSC_CTRL_PS_HI = 5;
  localparam logic [5:0] PWMSC_CTRL_RST = 6'h12;
  // output control register fields
  localparam int PWMSC_OUTC_INIT = 0;
  localparam int PWMSC_OUTC_PLVL = 1;
  localparam int PWMSC_OUTC_DLVL = 2;
  localparam logic [2:0] PWMSC_OUTC_RST = 3'h4;
  // status register fields
  localparam int PWMSC_STAT_OUT = 0;
  localparam int PWMSC_STAT_RUN = 1;
  // prescaler selections and terminal counts
  typedef enum logic [1:0] {
    PWMSC_DIV1 = 2'b00,
    PWMSC_DIV4 = 2'b01,
    PWMSC_DIV16 = 2'b10,
    PWMSC_DIV64 = 2'b11
  } pwmsc_div_t;
  localparam logic [5:0] PWMSC_LIM1 = 6'h00;
  localparam logic [5:0] PWMSC_LIM4 = 6'h03;
  localparam logic [5:0] PWMSC_LIM16 = 6'h0F;
  localparam logic [5:0] PWMSC_LIM64 = 6'h3F;
  localparam logic [31:0] PWMSC_RD_ZERO = 32'h0000_0000;
endpackage

/* File: pwmsc_top.sv */
// single-channel pwm generator with duty buffer and period match pulse
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - duty spans never-high to always-high purely from compare values
// - counter clears to zero on period match when clearing enabled
// - period match drives the pin to its configured level, low by default
// - duty match drives the pin to its configured level, high by default
// - pin starts from a configurable initial level, low by default
// - initial level appears when the output control register is written
// - with buffering on, the buffer supplies the next duty value
// - compare-match timing copies buffer into duty on each duty match
// - counter-clear timing copies buffer into duty on each counter clear
// - duty match during buffer write transfers the old buffer value
// - counter clear during buffer write transfers the old buffer value
// - larger duty loaded after its match gives a second match that period
// - second duty match while already at that level leaves the pin unchanged
// - each period match raises the period match interrupt pulse
// - late buffer write leaves duty unchanged through the next match
// - counter runs on a selectable prescaled tick, divide by four default
// - compare write during a match takes effect and match still occurs
module pwmsc_top
  import pwmsc_pkg::*;
#(
  parameter int W = 16
)(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_pwm,
  output logic o_period_match_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [5:0] div_lim(input logic [1:0] sel);
    case (sel)
      PWMSC_DIV1: div_lim = PWMSC_LIM1;
      PWMSC_DIV4: div_lim = PWMSC_LIM4;
      PWMSC_DIV16: div_lim = PWMSC_LIM16;
      PWMSC_DIV64: div_lim = PWMSC_LIM64;
      default: div_lim = PWMSC_LIM4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode

  logic [5:0] ctrl_q;
  logic [2:0] outc_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] duty_q;
  logic [W-1:0] per_q;
  logic [W-1:0] buf_q;
  logic [5:0] presc_q;
  logic out_q;
  logic irq_q;
  logic [31:0] rdata_q;

  logic wr_ctrl;
  logic wr_outc;
  logic wr_cnt;
  logic wr_duty;
  logic wr_per;
  logic wr_buf;
  logic run;
  logic tick;
  logic duty_match;
  logic per_match;
  logic cnt_clear;
  logic xfer;

  assign wr_ctrl = i_wr & hit(i_addr, PWMSC_OFS_CTRL);
  assign wr_outc = i_wr & hit(i_addr, PWMSC_OFS_OUTC);
  assign wr_cnt = i_wr & hit(i_addr, PWMSC_OFS_COUNT);
  assign wr_duty = i_wr & hit(i_addr, PWMSC_OFS_DUTY);
  assign wr_per = i_wr & hit(i_addr, PWMSC_OFS_PERIOD);
  assign wr_buf = i_wr & hit(i_addr, PWMSC_OFS_BUFFER);
  assign run = ctrl_q[PWMSC_CTRL_RUN];

  ////////////////////////////////////////////////////////////////////////////
  // prescaler

  assign tick = run & (presc_q >= div_lim(ctrl_q[PWMSC_CTRL_PS_HI:PWMSC_CTRL_PS_LO]));

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      presc_q <= '0;
    else if (!run || tick)
      presc_q <= '0;
    else
      presc_q <= presc_q + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare events, old register values used

  assign duty_match = tick & (cnt_q == duty_q);
  assign per_match = tick & (cnt_q == per_q);
  assign cnt_clear = per_match & ctrl_q[PWMSC_CTRL_CLR];
  assign xfer = ctrl_q[PWMSC_CTRL_BUF] &
    (ctrl_q[PWMSC_CTRL_XCLR] ? cnt_clear : duty_match);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      ctrl_q <= PWMSC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= i_wdata[5:0];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      outc_q <= PWMSC_OUTC_RST;
    else if (wr_outc)
      outc_q <= i_wdata[2:0];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      per_q <= '0;
    else if (wr_per)
      per_q <= i_wdata[W-1:0];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      buf_q <= '0;
    else if (wr_buf)
      buf_q <= i_wdata[W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt_q <= '0;
    else if (wr_cnt)
      cnt_q <= i_wdata[W-1:0];
    else if (cnt_clear)
      cnt_q <= '0;
    else if (tick)
      cnt_q <= cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty compare, software write wins over a buffer transfer

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      duty_q <= '0;
    else if (wr_duty)
      duty_q <= i_wdata[W-1:0];
    else if (xfer)
      duty_q <= buf_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pin; duty wins a tie so duty equal period stays at the duty level

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      out_q <= 1'b0;
    else if (wr_outc)
      out_q <= i_wdata[PWMSC_OUTC_INIT];
    else if (duty_match)
      out_q <= outc_q[PWMSC_OUTC_DLVL];
    else if (per_match)
      out_q <= outc_q[PWMSC_OUTC_PLVL];
  end

  assign o_pwm = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // period match interrupt pulse

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      irq_q <= 1'b0;
    else
      irq_q <= per_match;
  end

  assign o_period_match_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_q <= PWMSC_RD_ZERO;
    else if (!i_rd)
      rdata_q <= PWMSC_RD_ZERO;
    else
    begin
      case (i_addr)
        PWMSC_OFS_CTRL: rdata_q <= {26'h0, ctrl_q};
        PWMSC_OFS_OUTC: rdata_q <= {29'h0, outc_q};
        PWMSC_OFS_COUNT: rdata_q <= {{(32-W){1'b0}}, cnt_q};
        PWMSC_OFS_DUTY: rdata_q <= {{(32-W){1'b0}}, duty_q};
        PWMSC_OFS_PERIOD: rdata_q <= {{(32-W){1'b0}}, per_q};
        PWMSC_OFS_BUFFER: rdata_q <= {{(32-W){1'b0}}, buf_q};
        PWMSC_OFS_STATUS: rdata_q <= {30'h0, run, out_q};
        default: rdata_q <= PWMSC_RD_ZERO;
      endcase
    end
  end

  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cnt_clear && !wr_cnt) |=> (cnt_q == '0))
    else $error("counter not cleared on period match");

  AST_PER_LVL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (per_match && !duty_match && !wr_outc) |=> (o_pwm == $past(outc_q[PWMSC_OUTC_PLVL])))
    else $error("pin not at period level after period match");

  AST_DUTY_LVL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (duty_match && !wr_outc) |=> (o_pwm == $past(outc_q[PWMSC_OUTC_DLVL])))
    else $error("pin not at duty level after duty match");

  AST_INIT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_outc |=> (o_pwm == $past(i_wdata[PWMSC_OUTC_INIT])))
    else $error("initial level not shown after output control write");

  AST_XFER_CMP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ctrl_q[PWMSC_CTRL_BUF] && !ctrl_q[PWMSC_CTRL_XCLR] && duty_match && !wr_duty)
    |=> (duty_q == $past(buf_q)))
    else $error("buffer not transferred on duty match");

  AST_XFER_CLR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ctrl_q[PWMSC_CTRL_BUF] && ctrl_q[PWMSC_CTRL_XCLR] && cnt_clear && !wr_duty)
    |=> (duty_q == $past(buf_q)))
    else $error("buffer not transferred on counter clear");

  AST_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!xfer && !wr_duty) |=> $stable(duty_q))
    else $error("duty changed without transfer or write");

  AST_IRQ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    per_match |=> o_period_match_irq)
    else $error("period match pulse missing");

  AST_IRQ_OFF: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !per_match |=> !o_period_match_irq)
    else $error("period match pulse without a match");

  AST_BUF_OFF: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!ctrl_q[PWMSC_CTRL_BUF] && !wr_duty) |=> $stable(duty_q))
    else $error("duty moved with buffering off");

  AST_CLR_WAIT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ctrl_q[PWMSC_CTRL_BUF] && ctrl_q[PWMSC_CTRL_XCLR] && !cnt_clear && !wr_duty)
    |=> $stable(duty_q))
    else $error("duty moved between counter clears");

  AST_INC: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick && !cnt_clear && !wr_cnt) |=> (cnt_q == W'($past(cnt_q) + 1'b1)))
    else $error("counter did not step on tick");

  AST_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!run && !wr_cnt) |=> $stable(cnt_q))
    else $error("stopped counter moved");

  AST_DIRECT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_duty |=> (duty_q == $past(i_wdata[W-1:0])))
    else $error("duty write not taken");

  AST_STEADY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (duty_match && o_pwm == outc_q[PWMSC_OUTC_DLVL] && !wr_outc) |=> $stable(o_pwm))
    else $error("repeated duty match changed the pin");

  AST_DIV4: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick && ctrl_q == $past(ctrl_q) && ctrl_q[PWMSC_CTRL_PS_HI:PWMSC_CTRL_PS_LO] == PWMSC_DIV4
     && !wr_ctrl) |=> (!tick [*3]))
    else $error("divide by four tick spacing wrong");

endmodule
`default_nettype wire

/* File: pwmsc_stage.sv */
// behavioural switching stage that integrates the time it is switched on
`timescale 1ns/1ps
`default_nettype none
module pwmsc_stage
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_gate,
  output logic [15:0] o_on_cycles
);
  ////////////////////////////////////////
  // stage conducts in every cycle that the gate is high
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_on_cycles <= 16'h0000;
    end
    else
    begin
      o_on_cycles <= o_on_cycles + {15'h0000, i_gate};
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the single-channel pwm generator
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pwmsc_pkg::*;
;
  typedef struct packed {logic [5:0] ctrl; logic [2:0] outc; logic [7:0] per;
    logic [7:0] duty; logic [7:0] hi; logic [7:0] gap;} pwmsc_row_t;
  logic i_ref_clk, i_rst, i_wr, i_rd, o_pwm, o_period_match_irq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [15:0] on_cycles, h0;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  // control, output levels, period, duty, on cycles, irq spacing
  pwmsc_row_t rows [8] = '{'{6'h03, 3'h4, 8'h07, 8'h02, 8'h05, 8'h08},
    '{6'h03, 3'h4, 8'h07, 8'h00, 8'h07, 8'h08}, '{6'h03, 3'h4, 8'h07, 8'h07, 8'h08, 8'h08},
    '{6'h03, 3'h4, 8'h07, 8'h09, 8'h00, 8'h08}, '{6'h03, 3'h2, 8'h07, 8'h02, 8'h03, 8'h08},
    '{6'h13, 3'h4, 8'h05, 8'h01, 8'h10, 8'h18}, '{6'h23, 3'h4, 8'h03, 8'h01, 8'h20, 8'h40},
    '{6'h33, 3'h4, 8'h01, 8'h00, 8'h40, 8'h80}};
  ////////////////////////////////////////
  pwmsc_top #(.W(16)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm(o_pwm),
    .o_period_match_irq(o_period_match_irq));
  pwmsc_stage stage (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_gate(o_pwm),
    .o_on_cycles(on_cycles));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
    chk(nm, e, o_rdata);
  endtask
  task automatic wait_irq();
    n = 0;
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end
    while (o_period_match_irq !== 1'b1 && n < 600);
    if (o_period_match_irq !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] period pulse expected 1 seen 0");
      final_report();
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      miscompares++;
      final_report();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    chk("pin", 32'h0, {31'h0, o_pwm});
    for (int k = 0; k < 8; k++)
    begin
      rd(8'(k * 4), (k == 0) ? 32'h12 : (k == 1) ? 32'h4 : 32'h0, "reset value");
    end
    $display("test reset done");
    foreach (rows[r])
    begin
      wr(PWMSC_OFS_CTRL, {26'h0, rows[r].ctrl & 6'h3E});
      wr(PWMSC_OFS_COUNT, 32'h0);
      wr(PWMSC_OFS_PERIOD, {24'h0, rows[r].per});
      wr(PWMSC_OFS_DUTY, {24'h0, rows[r].duty});
      wr(PWMSC_OFS_OUTC, {29'h0, rows[r].outc});
      chk("pin start", 32'h0, {31'h0, o_pwm});
      wr(PWMSC_OFS_CTRL, {26'h0, rows[r].ctrl});
      wait_irq();
      h0 = on_cycles;
      wait_irq();
      chk("irq spacing", {24'h0, rows[r].gap}, 32'(n));
      chk("on cycles", {24'h0, rows[r].hi}, {16'h0, 16'(on_cycles - h0)});
      $display("test row %0d done", r);
    end
    // compare-match transfer, write colliding with the match
    wr(PWMSC_OFS_CTRL, 32'h6);
    wr(PWMSC_OFS_PERIOD, 32'hC);
    wr(PWMSC_OFS_DUTY, 32'h4);
    wr(PWMSC_OFS_BUFFER, 32'h4);
    wr(PWMSC_OFS_CTRL, 32'h7);
    wait_irq();
    h0 = on_cycles;
    wr(PWMSC_OFS_BUFFER, 32'h8);
    @(posedge i_ref_clk);
    wr(PWMSC_OFS_BUFFER, 32'h3);
    rd(PWMSC_OFS_DUTY, 32'h8, "duty at match");
    wait_irq();
    chk("on cycles", 32'h8, {16'h0, 16'(on_cycles - h0)});
    rd(PWMSC_OFS_DUTY, 32'h3, "duty transfer");
    $display("test compare transfer done");
    // counter-clear transfer, write colliding with the clear
    wr(PWMSC_OFS_CTRL, 32'hF);
    wr(PWMSC_OFS_BUFFER, 32'h6);
    wait_irq();
    rd(PWMSC_OFS_DUTY, 32'h6, "duty at clear");
    wait_irq();
    repeat (11) @(posedge i_ref_clk);
    wr(PWMSC_OFS_BUFFER, 32'h2);
    rd(PWMSC_OFS_DUTY, 32'h6, "duty old buffer");
    wait_irq();
    rd(PWMSC_OFS_DUTY, 32'h2, "duty new buffer");
    $display("test clear transfer done");
    // direct duty write landing on its own match
    wr(PWMSC_OFS_CTRL, 32'h3);
    wr(PWMSC_OFS_DUTY, 32'h4);
    wait_irq();
    repeat (3) @(posedge i_ref_clk);
    wr(PWMSC_OFS_DUTY, 32'hA);
    chk("pin at match", 32'h1, {31'h0, o_pwm});
    rd(PWMSC_OFS_DUTY, 32'hA, "duty written");
    rd(PWMSC_OFS_STATUS, 32'h3, "status running");
    $display("test write at match done");
    // stopped counter, output control, unmapped place
    wr(PWMSC_OFS_CTRL, 32'h2);
    wr(PWMSC_OFS_COUNT, 32'h5);
    repeat (10) @(posedge i_ref_clk);
    rd(PWMSC_OFS_COUNT, 32'h5, "count held");
    wr(PWMSC_OFS_OUTC, 32'h4);
    chk("pin init low", 32'h0, {31'h0, o_pwm});
    wr(PWMSC_OFS_OUTC, 32'h5);
    chk("pin init", 32'h1, {31'h0, o_pwm});
    rd(PWMSC_OFS_STATUS, 32'h1, "status stopped");
    @(posedge i_ref_clk);
    chk("rdata idle", 32'h0, o_rdata);
    wr(PWMSC_OFS_CTRL, 32'h1);
    wait_irq();
    rd(PWMSC_OFS_COUNT, 32'hE, "count past period");
    wr(8'h1C, 32'hFFFF);
    rd(8'h1C, 32'h0, "unmapped");
    $display("test stop and map done");
    final_report();
  end
endmodule
`default_nettype wire
